/* tmad_pkg.sv */
package tmad_pkg;

  // Register selector codes for transfer, swap and sign extension
  typedef enum logic [2:0] {
    TMAD_R_A = 3'h0,
    TMAD_R_B = 3'h1,
    TMAD_R_CONDITION_CODE_REG = 3'h2,
    TMAD_R_D = 3'h4,
    TMAD_R_X = 3'h5,
    TMAD_R_Y = 3'h6,
    TMAD_R_STACK_POINTER_REG = 3'h7
  } tmad_reg_t;

  // Operation codes issued by the core sequencer
  typedef enum logic [4:0] {
    TMAD_OP_NOP = 5'h00,
    TMAD_OP_XFER = 5'h01,
    TMAD_OP_TAB = 5'h02,
    TMAD_OP_COPY_ACC_B_TO_A = 5'h03,
    TMAD_OP_SEXT = 5'h04,
    TMAD_OP_SWAP = 5'h05,
    TMAD_OP_MEM_BYTE_COPY = 5'h06,
    TMAD_OP_MEM_WORD_COPY = 5'h07,
    TMAD_OP_ADDA = 5'h08,
    TMAD_OP_ADDB = 5'h09,
    TMAD_OP_ADD_CARRY_ACC_A = 5'h0A,
    TMAD_OP_ADD_CARRY_ACC_B = 5'h0B,
    TMAD_OP_SUBA = 5'h0C,
    TMAD_OP_SUBB = 5'h0D,
    TMAD_OP_SUB_BORROW_ACC_A = 5'h0E,
    TMAD_OP_SUB_BORROW_ACC_B = 5'h0F,
    TMAD_OP_ABA = 5'h10,
    TMAD_OP_SBA = 5'h11,
    TMAD_OP_ADD_B_TO_INDEX_X = 5'h12,
    TMAD_OP_ADD_B_TO_INDEX_Y = 5'h13,
    TMAD_OP_ADD_WORD_ACC_D = 5'h14,
    TMAD_OP_SUB_WORD_ACC_D = 5'h15
  } tmad_op_t;

  // Move addressing pairs; immediate is only ever a source
  typedef enum logic [2:0] {
    TMAD_MV_IMM_EXT = 3'h0,
    TMAD_MV_IMM_IDX = 3'h1,
    TMAD_MV_EXT_EXT = 3'h2,
    TMAD_MV_EXT_IDX = 3'h3,
    TMAD_MV_IDX_EXT = 3'h4,
    TMAD_MV_IDX_IDX = 3'h5
  } tmad_mvmode_t;

  // One command from the sequencer
  typedef struct packed {
    tmad_op_t op;
    tmad_reg_t src;
    tmad_reg_t dst;
    tmad_mvmode_t mv_mode;
    logic [15:0] imm;
    logic [15:0] src_addr;
    logic [15:0] dst_addr;
    logic [15:0] opnd_addr;
  } tmad_cmd_t;

  // Programmer-visible register file
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] condition_code_reg;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] stack_pointer_reg;
  } tmad_regs_t;

  // Condition code bit positions
  localparam int TMAD_CC_C = 0;
  localparam int TMAD_CC_V = 1;
  localparam int TMAD_CC_Z = 2;
  localparam int TMAD_CC_N = 3;

  // Reset values and the address step
  localparam logic [7:0] TMAD_BYTE_RST = 8'h00;
  localparam logic [15:0] TMAD_WORD_RST = 16'h0000;
  localparam logic [7:0] TMAD_CONDITION_CODE_RST = 8'hD0;
  localparam logic [15:0] TMAD_ADDR_STEP = 16'h0001;

endpackage

/* tmad_datapath.sv */
`timescale 1ns/1ps
module tmad_datapath (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire tmad_pkg::tmad_cmd_t cmd,
  output tmad_pkg::tmad_regs_t regs,
  output logic busy,
  output logic done,
  output logic mem_read,
  output logic mem_write,
  output logic [15:0] mem_address,
  output logic [7:0] mem_writedata,
  input wire logic [7:0] mem_readdata,
  input wire logic mem_waitrequest
);
  import tmad_pkg::*;

  // Sequencer states; memory is byte wide, a word is two byte cycles
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_HI, ST_RD_LO, ST_WR_HI, ST_WR_LO, ST_ALU
  } tmad_state_t;

  tmad_state_t state; // Current sequencer state
  tmad_cmd_t cur; // Latched command
  logic [15:0] data; // Fetched memory operand or move data
  logic [15:0] next_data; // Data after a completed read
  logic word_op; // Current command moves or fetches words
  logic [15:0] rd_addr; // Source address for the read phase
  logic [15:0] wr_addr; // Destination address for write phase
  logic src_is_imm; // Move source is the immediate field

  // 8-bit source value of a selector
  function automatic logic [7:0] get8(input tmad_regs_t r, input tmad_reg_t s);
    case (s)
      TMAD_R_A: get8 = r.a;
      TMAD_R_B: get8 = r.b;
      TMAD_R_CONDITION_CODE_REG: get8 = r.condition_code_reg;
      default: get8 = TMAD_BYTE_RST;
    endcase
  endfunction

  // 16-bit value; byte registers zero-extend
  function automatic logic [15:0] get16(input tmad_regs_t r, input tmad_reg_t s);
    case (s)
      TMAD_R_D: get16 = {r.a, r.b};
      TMAD_R_X: get16 = r.x;
      TMAD_R_Y: get16 = r.y;
      TMAD_R_STACK_POINTER_REG: get16 = r.stack_pointer_reg;
      default: get16 = {8'h00, get8(r, s)};
    endcase
  endfunction

  // Writes a value into a selector; byte targets take the low byte
  function automatic tmad_regs_t put(input tmad_regs_t r, input tmad_reg_t d, input logic [15:0] v);
    put = r;
    case (d)
      TMAD_R_A: put.a = v[7:0];
      TMAD_R_B: put.b = v[7:0];
      TMAD_R_CONDITION_CODE_REG: put.condition_code_reg = v[7:0];
      TMAD_R_D: {put.a, put.b} = v;
      TMAD_R_X: put.x = v;
      TMAD_R_Y: put.y = v;
      TMAD_R_STACK_POINTER_REG: put.stack_pointer_reg = v;
      default: put = r;
    endcase
  endfunction

  // Add or subtract with carry-in, flags per width
  function automatic logic [7:0] arith_cc(input logic [7:0] cc, input logic [15:0] x,
                                          input logic [15:0] y, input logic cin,
                                          input logic sub, input logic wide);
    logic [16:0] r;
    logic [15:0] yy;
    logic sx, sy, sr, c;
    r = 17'h00000;
    yy = sub ? ~y : y;
    r = {1'b0, x} + {1'b0, yy} + {16'h0000, sub ^ cin};
    arith_cc = cc;
    if (wide) begin
      sx = x[15]; sy = y[15]; sr = r[15]; c = r[16];
      arith_cc[TMAD_CC_Z] = (r[15:0] == 16'h0000);
    end else begin
      r = {1'b0, x[7:0]} + {1'b0, yy[7:0]} + {16'h0000, sub ^ cin};
      sx = x[7]; sy = y[7]; sr = r[7]; c = r[8];
      arith_cc[TMAD_CC_Z] = (r[7:0] == 8'h00);
    end
    arith_cc[TMAD_CC_N] = sr;
    arith_cc[TMAD_CC_V] = sub ? ((sx & ~sy & ~sr) | (~sx & sy & sr)) :
                                ((sx & sy & ~sr) | (~sx & ~sy & sr));
    arith_cc[TMAD_CC_C] = sub ? ~c : c; // borrow is inverted carry
  endfunction

  // Raw sum or difference, low 16 bits
  function automatic logic [15:0] arith_val(input logic [15:0] x, input logic [15:0] y,
                                            input logic cin, input logic sub);
    logic [15:0] yy;
    yy = sub ? ~y : y;
    arith_val = x + yy + {15'h0000, sub ^ cin};
  endfunction

  // Move side decode; immediate exists only on the source side
  always_comb begin
    // Word moves and D arithmetic take two byte cycles
    word_op = (cur.op == TMAD_OP_MEM_WORD_COPY) || (cur.op == TMAD_OP_ADD_WORD_ACC_D) ||
              (cur.op == TMAD_OP_SUB_WORD_ACC_D);
    src_is_imm = (cur.mv_mode == TMAD_MV_IMM_EXT) || (cur.mv_mode == TMAD_MV_IMM_IDX);
    rd_addr = (cur.op == TMAD_OP_MEM_BYTE_COPY || cur.op == TMAD_OP_MEM_WORD_COPY) ? cur.src_addr : cur.opnd_addr;
    wr_addr = cur.dst_addr; // destination is always an address
    next_data = data;
    if (state == ST_RD_HI && word_op) begin
      next_data = {mem_readdata, data[7:0]};
    end else if (state == ST_RD_HI || state == ST_RD_LO) begin
      next_data = {data[15:8], mem_readdata};
    end
  end

  // Sequencer: issue, memory phases, retire
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cur <= '0;
      data <= TMAD_WORD_RST;
      busy <= 1'b0;
      done <= 1'b0;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      mem_address <= TMAD_WORD_RST;
      mem_writedata <= TMAD_BYTE_RST;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            cur <= cmd;
            busy <= 1'b1;
            case (cmd.op)
              TMAD_OP_MEM_BYTE_COPY, TMAD_OP_MEM_WORD_COPY: begin
                if (cmd.mv_mode == TMAD_MV_IMM_EXT || cmd.mv_mode == TMAD_MV_IMM_IDX) begin
                  data <= cmd.imm; // Immediate needs no bus read
                  state <= (cmd.op == TMAD_OP_MEM_WORD_COPY) ? ST_WR_HI : ST_WR_LO;
                  mem_write <= 1'b1;
                  mem_address <= cmd.dst_addr;
                  mem_writedata <= (cmd.op == TMAD_OP_MEM_WORD_COPY) ? cmd.imm[15:8] : cmd.imm[7:0];
                end else begin
                  state <= ST_RD_HI;
                  mem_read <= 1'b1;
                  mem_address <= cmd.src_addr;
                end
              end
              TMAD_OP_ADDA, TMAD_OP_ADDB, TMAD_OP_ADD_CARRY_ACC_A, TMAD_OP_ADD_CARRY_ACC_B,
              TMAD_OP_SUBA, TMAD_OP_SUBB, TMAD_OP_SUB_BORROW_ACC_A, TMAD_OP_SUB_BORROW_ACC_B,
              TMAD_OP_ADD_WORD_ACC_D, TMAD_OP_SUB_WORD_ACC_D: begin // memory operand fetch
                state <= ST_RD_HI;
                mem_read <= 1'b1;
                mem_address <= cmd.opnd_addr;
              end
              default: state <= ST_ALU; // Register-only operations
            endcase
          end
        end
        ST_RD_HI, ST_RD_LO: begin
          if (!mem_waitrequest) begin
            data <= next_data;
            if (state == ST_RD_HI && word_op) begin
              state <= ST_RD_LO;
              mem_address <= rd_addr + TMAD_ADDR_STEP; // M+1
            end else if (cur.op == TMAD_OP_MEM_BYTE_COPY || cur.op == TMAD_OP_MEM_WORD_COPY) begin
              mem_read <= 1'b0;
              mem_write <= 1'b1;
              mem_address <= wr_addr;
              mem_writedata <= word_op ? next_data[15:8] : next_data[7:0];
              state <= word_op ? ST_WR_HI : ST_WR_LO;
            end else begin
              mem_read <= 1'b0;
              state <= ST_ALU;
            end
          end
        end
        ST_WR_HI: begin
          if (!mem_waitrequest) begin
            mem_address <= wr_addr + TMAD_ADDR_STEP; // consecutive word byte
            mem_writedata <= data[7:0];
            state <= ST_WR_LO;
          end
        end
        ST_WR_LO: begin
          if (!mem_waitrequest) begin
            mem_write <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_ALU: begin
          busy <= 1'b0;
          done <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Register file update at the retire cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regs.a <= TMAD_BYTE_RST;
      regs.b <= TMAD_BYTE_RST;
      regs.condition_code_reg <= TMAD_CONDITION_CODE_RST;
      regs.x <= TMAD_WORD_RST;
      regs.y <= TMAD_WORD_RST;
      regs.stack_pointer_reg <= TMAD_WORD_RST;
    end else if (state == ST_ALU) begin
      case (cur.op)
        TMAD_OP_XFER: begin
          // Byte-to-word copies zero-extend; flags stay as they are unless the condition code register is the target
          regs <= put(regs, cur.dst, get16(regs, cur.src));
        end
        TMAD_OP_TAB, TMAD_OP_COPY_ACC_B_TO_A: begin
          // Legacy copies: N and Z from data, V cleared, C kept
          logic [7:0] v;
          tmad_regs_t t;
          v = (cur.op == TMAD_OP_TAB) ? regs.a : regs.b;
          t = regs;
          if (cur.op == TMAD_OP_TAB) t.b = v; else t.a = v;
          t.condition_code_reg[TMAD_CC_N] = v[7];
          t.condition_code_reg[TMAD_CC_Z] = (v == 8'h00);
          t.condition_code_reg[TMAD_CC_V] = 1'b0;
          regs <= t;
        end
        TMAD_OP_SEXT: begin
          // Only byte sources and word targets are meaningful
          logic [7:0] s;
          s = get8(regs, cur.src);
          if (cur.dst[2]) begin
            regs <= put(regs, cur.dst, {{8{s[7]}}, s});
          end
        end
        TMAD_OP_SWAP: begin
          // Both values read before either write, so one edge swaps
          logic [15:0] vs, vd;
          tmad_regs_t t;
          vs = get16(regs, cur.src);
          vd = get16(regs, cur.dst);
          t = put(regs, cur.dst, vs);
          regs <= put(t, cur.src, vd);
        end
        TMAD_OP_ADDA, TMAD_OP_ADD_CARRY_ACC_A, TMAD_OP_SUBA, TMAD_OP_SUB_BORROW_ACC_A,
        TMAD_OP_ABA, TMAD_OP_SBA: begin
          logic sub, cin;
          logic [15:0] y;
          logic [15:0] sum; // Full sum; only the low byte is kept
          sub = (cur.op == TMAD_OP_SUBA) || (cur.op == TMAD_OP_SUB_BORROW_ACC_A) || (cur.op == TMAD_OP_SBA);
          cin = ((cur.op == TMAD_OP_ADD_CARRY_ACC_A) || (cur.op == TMAD_OP_SUB_BORROW_ACC_A)) &
                regs.condition_code_reg[TMAD_CC_C];
          y = (cur.op == TMAD_OP_ABA || cur.op == TMAD_OP_SBA) ? {8'h00, regs.b} : data;
          sum = arith_val({8'h00, regs.a}, y, cin, sub);
          regs.a <= sum[7:0];
          regs.condition_code_reg <= arith_cc(regs.condition_code_reg, {8'h00, regs.a}, y, cin, sub, 1'b0);
        end
        TMAD_OP_ADDB, TMAD_OP_ADD_CARRY_ACC_B, TMAD_OP_SUBB, TMAD_OP_SUB_BORROW_ACC_B: begin
          logic sub, cin;
          logic [15:0] sum; // Full sum; only the low byte is kept
          sub = (cur.op == TMAD_OP_SUBB) || (cur.op == TMAD_OP_SUB_BORROW_ACC_B);
          cin = ((cur.op == TMAD_OP_ADD_CARRY_ACC_B) || (cur.op == TMAD_OP_SUB_BORROW_ACC_B)) &
                regs.condition_code_reg[TMAD_CC_C];
          sum = arith_val({8'h00, regs.b}, data, cin, sub);
          regs.b <= sum[7:0];
          regs.condition_code_reg <= arith_cc(regs.condition_code_reg, {8'h00, regs.b}, data, cin, sub, 1'b0);
        end
        TMAD_OP_ADD_B_TO_INDEX_X: regs.x <= regs.x + {8'h00, regs.b}; // flags untouched
        TMAD_OP_ADD_B_TO_INDEX_Y: regs.y <= regs.y + {8'h00, regs.b};
        TMAD_OP_ADD_WORD_ACC_D, TMAD_OP_SUB_WORD_ACC_D: begin
          logic sub;
          sub = (cur.op == TMAD_OP_SUB_WORD_ACC_D);
          {regs.a, regs.b} <= arith_val({regs.a, regs.b}, data, 1'b0, sub);
          regs.condition_code_reg <= arith_cc(regs.condition_code_reg, {regs.a, regs.b}, data, 1'b0, sub,
                                              1'b1);
        end
        default: regs <= regs;
      endcase
    end
  end

endmodule

/* tmad_datapath_asserts.sv */
`timescale 1ns/1ps
// Port-level checks on the datapath
module tmad_datapath_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire tmad_pkg::tmad_cmd_t cmd,
  input wire tmad_pkg::tmad_regs_t regs,
  input wire logic busy,
  input wire logic done,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [15:0] mem_address,
  input wire logic [7:0] mem_writedata,
  input wire logic [7:0] mem_readdata,
  input wire logic mem_waitrequest
);
  import tmad_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Command accepted at this edge
  logic take;
  assign take = cmd_valid && !busy;
  a_rw_excl: assert property (!(mem_read && mem_write)) else $error("read and write together");
  a_read_hold: assert property (mem_read && mem_waitrequest |=> mem_read && $stable(mem_address))
    else $error("read dropped during stall");
  a_write_hold: assert property (mem_write && mem_waitrequest |=> mem_write && $stable(mem_address)
    && $stable(mem_writedata)) else $error("write changed during stall");
  a_idle_quiet: assert property (!busy |-> !mem_read && !mem_write) else $error("bus active while idle");
  a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
  a_reg_latency: assert property (take && cmd.op == TMAD_OP_XFER |=> busy ##1 (done && !busy))
    else $error("transfer latency wrong");
  a_xfer_flags: assert property (take && cmd.op == TMAD_OP_XFER && cmd.dst != TMAD_R_CONDITION_CODE_REG
    |-> ##2 regs.condition_code_reg == $past(regs.condition_code_reg, 2)) else $error("transfer changed flags");
  a_xfer_copy: assert property (take && cmd.op == TMAD_OP_XFER && cmd.src == TMAD_R_X && cmd.dst == TMAD_R_Y
    |-> ##2 regs.y == $past(regs.x, 2) && regs.x == $past(regs.x, 2)) else $error("transfer copy wrong");
  a_sext_msb: assert property (take && cmd.op == TMAD_OP_SEXT && cmd.src == TMAD_R_A && cmd.dst == TMAD_R_X
    |-> ##2 regs.x == {{8{$past(regs.a[7], 2)}}, $past(regs.a, 2)}) else $error("sign extension wrong");
  a_idx_add: assert property (take && cmd.op == TMAD_OP_ADD_B_TO_INDEX_X
    |-> ##2 regs.x == $past(regs.x, 2) + {8'h00, $past(regs.b, 2)}) else $error("index add wrong");
  a_imm_dest: assert property (take && (cmd.op == TMAD_OP_MEM_BYTE_COPY || cmd.op == TMAD_OP_MEM_WORD_COPY)
    && cmd.mv_mode <= TMAD_MV_IMM_IDX |=> mem_write && mem_address == $past(cmd.dst_addr))
    else $error("immediate move did not write first");
  a_word_bound: assert property (take && cmd.op == TMAD_OP_MEM_WORD_COPY |-> ##[3:400] done)
    else $error("word move never finished");
  // Main scenarios reached
  c_word_move: cover property (take && cmd.op == TMAD_OP_MEM_WORD_COPY);
  c_stall: cover property (mem_read && mem_waitrequest);
  c_word_sub: cover property (take && cmd.op == TMAD_OP_SUB_WORD_ACC_D);
endmodule

/* tmad_mem_model.sv */
`timescale 1ns/1ps
// Memory on the common bus, with optional random stalls
module tmad_mem_model (
  input wire logic clk,
  input wire logic stall_en,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [15:0] mem_address,
  input wire logic [7:0] mem_writedata,
  output logic [7:0] mem_readdata,
  output logic mem_waitrequest
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_rd = 8'h5A;
  logic [15:0] rng = 16'hACE1;
  // Stall pattern source, independent of the bench sequence
  always @(posedge clk) rng <= {rng[14:0], rng[15] ^ rng[13] ^ rng[12] ^ rng[10]};
  // Every access is answered, late when stalling
  assign mem_waitrequest = !(mem_read || mem_write) || (stall_en && rng[0]);
  // Data valid only at the accepting edge; scrambled otherwise so stale data is not trusted
  assign mem_readdata = (mem_read && !mem_waitrequest) ? mem[mem_address] : ~last_rd;
  always @(posedge clk) begin
    if (mem_read && !mem_waitrequest) last_rd <= mem[mem_address];
    if (mem_write && !mem_waitrequest) mem[mem_address] <= mem_writedata;
  end
endmodule

/* transfer_move_addsub_datapath_tb.sv */
`timescale 1ns/1ps
// Bench: integer model checked at every retired command
module transfer_move_addsub_datapath_tb;
  import tmad_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic stall_en = 1'b0;
  tmad_cmd_t cmd = '0;
  tmad_regs_t regs;
  logic busy, done, mem_read, mem_write, mem_waitrequest;
  logic [15:0] mem_address;
  logic [7:0] mem_writedata, mem_readdata;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [31:0] lfsr_q = 32'h75413C90;
  int ea, eb, ec, ex, ey, es, op, s, d;
  int em [0:255];
  int sel [7] = '{0, 1, 2, 4, 5, 6, 7};

  initial forever #4 clk = ~clk;

  tmad_datapath uut (.clk, .resetn, .cmd_valid, .cmd, .regs, .busy, .done, .mem_read, .mem_write,
    .mem_address, .mem_writedata, .mem_readdata, .mem_waitrequest);
  tmad_mem_model mem_u (.clk, .stall_en, .mem_read, .mem_write, .mem_address, .mem_writedata,
    .mem_readdata, .mem_waitrequest);

  // Eight shifts per call to decorrelate draws
  function logic [31:0] rnd();
    for (int i = 0; i < 8; i++) lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  task chk(string what, logic [71:0] seen, logic [71:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task final_report();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function logic [71:0] exp_regs();
    return {ea[7:0], eb[7:0], ec[7:0], ex[15:0], ey[15:0], es[15:0]};
  endfunction

  // Register read by selector; bytes come back zero-extended
  function int gr(int r);
    case (r)
      0: return ea;
      1: return eb;
      2: return ec;
      4: return ea * 256 + eb;
      5: return ex;
      6: return ey;
      7: return es;
      default: return 0;
    endcase
  endfunction

  // Register write by selector; a byte register keeps the low byte
  task sr(int r, int v);
    case (r)
      0: ea = v & 255;
      1: eb = v & 255;
      2: ec = v & 255;
      4: begin ea = (v >> 8) & 255; eb = v & 255; end
      5: ex = v & 65535;
      6: ey = v & 65535;
      7: es = v & 65535;
      default: ;
    endcase
  endtask

  function int nz(int v, int w);
    return (((v >> (w - 1)) & 1) ? 8 : 0) | ((v == 0) ? 4 : 0);
  endfunction

  // Two's complement add or subtract; carry doubles as borrow
  task ar(int w, int x, int y, int ci, logic sb, output int r);
    int m, h, ov, cy;
    m = (1 << w) - 1;
    h = 1 << (w - 1);
    r = sb ? x - y - ci : x + y + ci;
    cy = (r < 0 || r > m) ? 1 : 0;
    r = r & m;
    ov = sb ? ((x ^ y) & (x ^ r) & h) : (~(x ^ y) & (x ^ r) & h);
    ec = (ec & 8'hF0) | nz(r, w) | ((ov != 0) ? 2 : 0) | cy;
  endtask

  task do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    ea = 0; eb = 0; ex = 0; ey = 0; es = 0; ec = 8'hD0;
    #1;
    chk("reset regs", regs, exp_regs());
    $display("Test reset done");
  endtask

  // Issue one command, wait for retire, update model and compare
  task run(int o, int rs, int rd);
    tmad_cmd_t c;
    int v, w, r, k;
    c = '0;
    c.op = tmad_op_t'(o[4:0]);
    c.src = tmad_reg_t'(rs[2:0]);
    c.dst = tmad_reg_t'(rd[2:0]);
    c.mv_mode = tmad_mvmode_t'(3'(rnd() % 6));
    c.imm = rnd();
    c.src_addr = 16'(rnd() % 255);
    c.dst_addr = 16'(rnd() % 255);
    c.opnd_addr = 16'(rnd() % 255);
    @(posedge clk);
    cmd <= c;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    k = 0;
    do begin @(posedge clk); #1; k++; end while (done !== 1'b1 && k < 500);
    if (k >= 500) begin
      n_mismatch++;
      $display("[ERR] done wait expected 1 seen timeout");
      final_report();
    end
    case (o)
      1: sr(rd, gr(rs));
      2, 3: begin v = (o == 2) ? ea : eb; sr(o == 2 ? 1 : 0, v); ec = (ec & 8'hF1) | nz(v, 8); end
      4: if (rd >= 4) sr(rd, (gr(rs) & 128) ? gr(rs) | 16'hFF00 : gr(rs));
      5: begin v = gr(rs); sr(rs, gr(rd)); sr(rd, v); end
      6, 7: begin
        v = (c.mv_mode < 2) ? ((o == 7) ? c.imm[15:8] : c.imm[7:0]) : em[c.src_addr];
        w = (c.mv_mode < 2) ? c.imm[7:0] : em[c.src_addr + 1];
        em[c.dst_addr] = v;
        if (o == 7) em[c.dst_addr + 1] = w;
      end
      8, 9, 10, 11, 12, 13, 14, 15: begin
        ar(8, o[0] ? eb : ea, em[c.opnd_addr], o[1] ? (ec & 1) : 0, o[2], r);
        sr(o[0] ? 1 : 0, r);
      end
      16, 17: begin ar(8, ea, eb, 0, o[0], r); ea = r; end
      18: ex = (ex + eb) & 65535;
      19: ey = (ey + eb) & 65535;
      20, 21: begin ar(16, gr(4), em[c.opnd_addr] * 256 + em[c.opnd_addr + 1], 0, o[0], r); sr(4, r); end
      default: ;
    endcase
    chk("regs", regs, exp_regs());
    chk("dest bytes", {mem_u.mem[c.dst_addr], mem_u.mem[c.dst_addr + 1]},
      {em[c.dst_addr][7:0], em[c.dst_addr + 1][7:0]});
  endtask

  initial begin
    for (int i = 0; i < 256; i++) begin
      em[i] = rnd() & 255;
      mem_u.mem[i] = em[i][7:0];
    end
    do_reset();
    // Every operation except NOP in turn, twice so registers hold data
    for (int p = 0; p < 2; p++) for (int k = 1; k < 22; k++) run(k, (k == 1) ? 5 : 0, (k == 1) ? 6 : 5);
    $display("Test directed done");
    stall_en <= 1'b1;
    for (int n = 0; n < 400; n++) begin
      op = 1 + rnd() % 21;
      s = (op == 4) ? sel[rnd() % 3] : sel[rnd() % 7];
      d = sel[rnd() % 7];
      // Avoid D against its own halves, where write order is open
      if ((s == 4 && d < 2) || (d == 4 && s < 2)) d = 5;
      run(op, s, d);
    end
    $display("Test random done");
    do_reset();
    for (int k = 8; k < 22; k++) run(k, 0, 5);
    $display("Test after second reset done");
    final_report();
  end
endmodule

bind tmad_datapath tmad_datapath_asserts chk_u (.clk, .resetn, .cmd_valid, .cmd, .regs, .busy, .done,
  .mem_read, .mem_write, .mem_address, .mem_writedata, .mem_readdata, .mem_waitrequest);
